// ==== rtl/aspsq_pkg.sv ====
// Constants and types shared by the phase-spread and sequencing block.
package aspsq_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses on the APB side)
  // ---------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL      = 12'h000;
  localparam logic [11:0] OFS_SEQ_ID    = 12'h004;
  localparam logic [11:0] OFS_FAULT_ST  = 12'h008;
  localparam logic [11:0] OFS_FAULT_MSK = 12'h00c;
  localparam logic [11:0] OFS_STATUS    = 12'h010;
  localparam logic [11:0] OFS_RESTORE   = 12'h014;
  localparam logic [11:0] OFS_FAN_PULSE_INPUT_RPM  = 12'h018;
  localparam logic [11:0] OFS_TELEM0    = 12'h020;
  localparam logic [11:0] OFS_TELEM6    = 12'h038;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int CTRL_PROG_LSB  = 0;
  localparam int CTRL_USE_PROG  = 4;
  localparam int CTRL_CMD_SEQ   = 5;
  localparam int CTRL_FAN_PULSE_INPUT_ALW  = 6;
  localparam int SEQ_SUCC_LSB   = 8;
  localparam int SEQ_PRED_V     = 7;
  localparam int SEQ_SUCC_V     = 15;
  localparam int RST_DEF_BIT    = 0;
  localparam int RST_FAC_BIT    = 1;
  localparam int RST_REFUSE_BIT = 2;
  localparam int FLT_PEER_BIT   = 7;
  localparam logic [7:0] FAULT_MSK_RST = 8'hff;

  // ---------------------------------------------------------------
  // Addressing, phase and timing
  // ---------------------------------------------------------------
  localparam logic [6:0] ADDR_BASE    = 7'h20;  // Strap low/low address.
  localparam int         GROUP_LSB    = 3;      // Group = address above bit 2.
  localparam int         PHASE_SLOTS  = 16;     // 22.5 degree slots per period.
  localparam int         ADDR_PHASE_K = 2;      // 45 degrees = two slots.
  localparam int         RPM_PER_PPS  = 60;     // One pulse per revolution.
  localparam int         FAN_PULSE_INPUT_WIN_MS  = 1000;
  localparam int         CLK_KHZ      = 250000;
  localparam int         FAN_PULSE_INPUT_WIN_CYC = FAN_PULSE_INPUT_WIN_MS * CLK_KHZ;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {EVT_NONE, EVT_ON, EVT_OFF, EVT_FAULT} aspsq_kind_t;
  typedef enum logic [1:0] {ROLE_NONE, ROLE_FIRST, ROLE_LAST, ROLE_MID} aspsq_role_t;
  typedef enum logic [1:0] {SYNC_IN, SYNC_AUTO, SYNC_OUT} aspsq_sync_t;
  typedef enum logic [1:0] {STORE_NONE, STORE_DEFAULT, STORE_USER} aspsq_store_t;
  typedef enum {SEQ_OFF, SEQ_WAIT_ON, SEQ_RAMP, SEQ_ON, SEQ_WAIT_OFF, SEQ_STOP} aspsq_seq_t;

  typedef struct packed {
    logic        valid;
    aspsq_kind_t kind;
    logic [6:0]  addr;
  } aspsq_evt_t;

  typedef struct packed {
    logic [15:0] vin;
    logic [15:0] vout;
    logic [15:0] iout;
    logic [15:0] temp_int;
    logic [15:0] temp_ext;
    logic [15:0] freq;
    logic [15:0] duty;
  } aspsq_telem_t;

endpackage

// ==== rtl/aspsq_top.sv ====
// Phase spreading, autonomous sequencing, configuration decode and monitoring.
//
// Overview of operation
// [R1] Switching cycle starts address times 45 degrees into the shared period.
// [R2] Only the three lowest address bits set the address-based offset.
// [R3] Programmed offset runs 0 to 337.5 degrees in 22.5 degree steps.
// [R4] All phase-spread converters share one switching clock (system duty).
// [R5] Each device broadcasts its sequencing status on the shared lines, hostless.
// [R6] Chain members get consecutive addresses with none missing (system duty).
// [R7] Autonomous sequencing forces the address offset, ignoring the programmed one.
// [R8] Turn-on runs lowest address first, each waiting for its predecessor.
// [R9] Turn-off runs highest address first, each waiting for its successor.
// [R10] Config 10, 11, 12.1 kohm: no sequencing; sync input, auto, output.
// [R11] Config 14.7, 16.2, 17.8 kohm: first group member; sync in, auto, out.
// [R12] Config 21.5, 23.7, 26.1 kohm: last group member; sync in, auto, out.
// [R13] Config 31.6, 34.8, 38.3 kohm: middle member; sync in, auto, out.
// [R14] Command sequencing uses host-set predecessor and successor, any offset.
// [R15] Events are exchanged only within the same address group.
// [R16] Rising enable starts sequenced turn-on, falling enable sequenced turn-off.
// [R17] Alert asserts on any enabled fault or warning.
// [R18] Input and output voltage, current, temperatures, frequency, duty are readable.
// [R19] Fan pulse rate becomes RPM at one pulse per revolution.
// [R20] Fan pulses are counted only while enabled or monitoring always.
// [R21] Initialization checks the default and user stores for saved settings.
// [R22] With the default store in use, factory restore is refused.
// [R23] Bus address comes from two three-level address straps.
`timescale 1ns/1ps

module aspsq_top
  import aspsq_pkg::*;
#(
  parameter int FAN_PULSE_INPUT_WINDOW = FAN_PULSE_INPUT_WIN_CYC
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire logic [1:0]   address_strap_low,
  input  wire logic [1:0]   address_strap_high,
  input  wire logic [4:0]   cfg_index,
  input  wire logic         default_store_ok,
  input  wire logic         user_store_ok,
  input  wire logic         enable_in,
  input  wire logic         power_good,
  input  wire logic         period_start,
  input  wire logic         slot_tick,
  input  wire logic [6:0]   fault_in,
  input  wire logic         fan_pulse_input,
  input  wire aspsq_telem_t telem,
  input  wire aspsq_evt_t   evt_in,
  output aspsq_evt_t        evt_out,
  output logic              run_req,
  output logic              cycle_start,
  output logic [1:0]        sync_mode,
  output logic              fault_alert_line,
  output logic              restore_default_req,
  output logic              restore_factory_req
);

  // ---------------------------------------------------------------
  // Elaboration check
  // ---------------------------------------------------------------
  if (FAN_PULSE_INPUT_WINDOW < 1 || FAN_PULSE_INPUT_WINDOW > 268435455) begin : g_bad_window
    $error("FAN_PULSE_INPUT_WINDOW must fit a 28-bit counter and be at least one");
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    aspsq_seq_t   seq;
    logic         init_done;
    logic [6:0]   dev_addr;
    aspsq_role_t  role;
    aspsq_sync_t  sync;
    aspsq_store_t store;
    logic         en_q;
    logic [7:0]   fstat;
    logic [7:0]   fmask;
    logic [3:0]   prog;
    logic         use_prog;
    logic         cmd_seq;
    logic         fan_pulse_input_alw;
    logic [6:0]   pred;
    logic         pred_v;
    logic [6:0]   succ;
    logic         succ_v;
    logic         refused;
    logic         rst_def;
    logic         rst_fac;
    logic [31:0]  rdata;
    logic [3:0]   slot;
    logic         cyc;
    aspsq_evt_t   evt;
    logic         alert_q;
    logic         fan_pulse_input_q;
    logic [15:0]  fan_pulse_input_cnt;
    logic [27:0]  win_cnt;
    logic [31:0]  rpm;
  } aspsq_state_t;

  aspsq_state_t st_reg;
  aspsq_state_t st_next;

  // ---------------------------------------------------------------
  // Combinational helpers
  // ---------------------------------------------------------------
  logic       wr_acc;
  logic       rd_setup;
  logic       mapped;
  logic       auto_seq;
  logic [3:0] phase_eff;
  logic [6:0] pred_id;
  logic [6:0] succ_id;
  logic       need_pred;
  logic       need_succ;
  logic       in_group;
  logic       pred_on;
  logic       succ_off;
  logic       en_rise;
  logic       en_fall;
  logic       fan_pulse_input_on;
  logic       alert_now;
  logic [3:0] strap_idx;

  // APB strobes; the slave answers with no wait states.
  assign wr_acc   = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign mapped   = (paddr <= OFS_FAN_PULSE_INPUT_RPM && paddr[1:0] == 2'b00)
                  || (paddr >= OFS_TELEM0 && paddr <= OFS_TELEM6 && paddr[1:0] == 2'b00);
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~mapped;

  // Autonomous mode is any sequencing role without host-assigned neighbours.
  assign auto_seq  = (st_reg.role != ROLE_NONE) & ~st_reg.cmd_seq;
  // Address offset is two 22.5 degree slots per address step. A programmed
  // offset is honoured only outside autonomous sequencing. [R7]
  assign phase_eff = (!auto_seq && st_reg.use_prog) ? st_reg.prog     // [R3] [R14]
                   : {st_reg.dev_addr[2:0], 1'b0};                    // [R1] [R2]

  // Neighbour identities: address plus or minus one, or host-assigned.
  assign pred_id   = st_reg.cmd_seq ? st_reg.pred : 7'(st_reg.dev_addr - 7'd1);   // [R14]
  assign succ_id   = st_reg.cmd_seq ? st_reg.succ : 7'(st_reg.dev_addr + 7'd1);   // [R14]
  assign need_pred = st_reg.cmd_seq ? st_reg.pred_v
                   : (st_reg.role == ROLE_LAST || st_reg.role == ROLE_MID);       // [R8]
  assign need_succ = st_reg.cmd_seq ? st_reg.succ_v
                   : (st_reg.role == ROLE_FIRST || st_reg.role == ROLE_MID);      // [R9]

  // Only peers sharing the upper address bits are heard. [R15]
  assign in_group  = evt_in.valid
                   && evt_in.addr[6:GROUP_LSB] == st_reg.dev_addr[6:GROUP_LSB];
  assign pred_on   = in_group && evt_in.kind == EVT_ON && evt_in.addr == pred_id;
  assign succ_off  = in_group && evt_in.kind == EVT_OFF && evt_in.addr == succ_id;

  assign en_rise   = enable_in & ~st_reg.en_q;
  assign en_fall   = ~enable_in & st_reg.en_q;
  assign fan_pulse_input_on   = enable_in | st_reg.fan_pulse_input_alw;
  assign alert_now = |(st_reg.fstat & st_reg.fmask);

  // Straps read 0 low, 1 open, 2 high; the high/high code is reserved.
  assign strap_idx = 4'(address_strap_low) + 4'(3 * address_strap_high);

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    st_next     = st_reg;
    st_next.cyc = 1'b0;
    st_next.evt = '0;
    st_next.rst_def = 1'b0;
    st_next.rst_fac = 1'b0;
    st_next.en_q    = enable_in;

    // Straps, config resistor and stores are caught once, after reset release.
    if (!st_reg.init_done) begin
      st_next.init_done = 1'b1;
      st_next.dev_addr  = (strap_idx > 4'd7) ? ADDR_BASE : 7'(ADDR_BASE + 7'(strap_idx)); // [R23]
      if (default_store_ok) begin
        st_next.store = STORE_DEFAULT;       // [R21]
      end else if (user_store_ok) begin
        st_next.store = STORE_USER;          // [R21]
      end else begin
        st_next.store = STORE_NONE;
      end
      case (cfg_index)
        5'd0:    begin st_next.role = ROLE_NONE;  st_next.sync = SYNC_IN;   end // [R10]
        5'd1:    begin st_next.role = ROLE_NONE;  st_next.sync = SYNC_AUTO; end // [R10]
        5'd2:    begin st_next.role = ROLE_NONE;  st_next.sync = SYNC_OUT;  end // [R10]
        5'd4:    begin st_next.role = ROLE_FIRST; st_next.sync = SYNC_IN;   end // [R11]
        5'd5:    begin st_next.role = ROLE_FIRST; st_next.sync = SYNC_AUTO; end // [R11]
        5'd6:    begin st_next.role = ROLE_FIRST; st_next.sync = SYNC_OUT;  end // [R11]
        5'd8:    begin st_next.role = ROLE_LAST;  st_next.sync = SYNC_IN;   end // [R12]
        5'd9:    begin st_next.role = ROLE_LAST;  st_next.sync = SYNC_AUTO; end // [R12]
        5'd10:   begin st_next.role = ROLE_LAST;  st_next.sync = SYNC_OUT;  end // [R12]
        5'd12:   begin st_next.role = ROLE_MID;   st_next.sync = SYNC_IN;   end // [R13]
        5'd13:   begin st_next.role = ROLE_MID;   st_next.sync = SYNC_AUTO; end // [R13]
        5'd14:   begin st_next.role = ROLE_MID;   st_next.sync = SYNC_OUT;  end // [R13]
        default: begin st_next.role = ROLE_NONE;  st_next.sync = SYNC_IN;   end
      endcase
    end

    // Phase slot counter; the period marker wins over the slot tick.
    if (period_start) begin
      st_next.slot = 4'd0;
      st_next.cyc  = (phase_eff == 4'd0);    // [R1]
    end else if (slot_tick) begin
      st_next.slot = 4'(st_reg.slot + 4'd1);
      st_next.cyc  = (4'(st_reg.slot + 4'd1) == phase_eff);   // [R1]
    end

    // Sequencer. A fault spread from a group peer drops the output at once.
    case (st_reg.seq)
      SEQ_OFF: begin
        if (en_rise) begin
          st_next.seq = need_pred ? SEQ_WAIT_ON : SEQ_RAMP;   // [R16] [R8]
        end
      end
      SEQ_WAIT_ON: begin
        if (!enable_in) begin
          st_next.seq = SEQ_OFF;
        end else if (pred_on) begin
          st_next.seq = SEQ_RAMP;                            // [R8]
        end
      end
      SEQ_RAMP: begin
        if (!enable_in) begin
          st_next.seq = SEQ_STOP;
        end else if (power_good) begin
          st_next.seq = SEQ_ON;
          st_next.evt = '{1'b1, EVT_ON, st_reg.dev_addr};   // [R5]
        end
      end
      SEQ_ON: begin
        if (en_fall || !enable_in) begin
          st_next.seq = need_succ ? SEQ_WAIT_OFF : SEQ_STOP; // [R16] [R9]
        end
      end
      SEQ_WAIT_OFF: begin
        if (succ_off) begin
          st_next.seq = SEQ_STOP;                            // [R9]
        end
      end
      SEQ_STOP: begin
        if (!power_good) begin
          st_next.seq = SEQ_OFF;
          st_next.evt = '{1'b1, EVT_OFF, st_reg.dev_addr};  // [R5]
        end
      end
      default: st_next.seq = SEQ_OFF;
    endcase

    // Fault spreading: a new local alert is broadcast, a peer fault stops us.
    st_next.alert_q = alert_now;
    if (alert_now && !st_reg.alert_q) begin
      st_next.evt = '{1'b1, EVT_FAULT, st_reg.dev_addr};    // [R5]
    end
    if (in_group && evt_in.kind == EVT_FAULT && st_reg.seq != SEQ_OFF) begin
      st_next.seq = SEQ_STOP;                                // [R15]
    end

    // Fan tachometer: pulses per window, scaled to revolutions per minute.
    st_next.fan_pulse_input_q = fan_pulse_input;
    if (st_reg.win_cnt == 28'(FAN_PULSE_INPUT_WINDOW - 1)) begin
      st_next.win_cnt  = 28'd0;
      st_next.fan_pulse_input_cnt = 16'(fan_pulse_input_on && fan_pulse_input && !st_reg.fan_pulse_input_q);   // [R20]
      st_next.rpm      = 32'(st_reg.fan_pulse_input_cnt) * 32'(RPM_PER_PPS);   // [R19]
    end else begin
      st_next.win_cnt = 28'(st_reg.win_cnt + 28'd1);
      if (fan_pulse_input_on && fan_pulse_input && !st_reg.fan_pulse_input_q && st_reg.fan_pulse_input_cnt != 16'hffff) begin
        st_next.fan_pulse_input_cnt = 16'(st_reg.fan_pulse_input_cnt + 16'd1);    // [R20]
      end
    end

    // Register writes. Software clears faults, but a new event wins. [R17]
    if (wr_acc && paddr == OFS_CTRL) begin
      st_next.prog     = pwdata[CTRL_PROG_LSB +: 4];         // [R3]
      st_next.use_prog = pwdata[CTRL_USE_PROG];
      st_next.cmd_seq  = pwdata[CTRL_CMD_SEQ];               // [R14]
      st_next.fan_pulse_input_alw = pwdata[CTRL_FAN_PULSE_INPUT_ALW];              // [R20]
    end
    if (wr_acc && paddr == OFS_SEQ_ID) begin
      st_next.pred   = pwdata[6:0];                          // [R14]
      st_next.pred_v = pwdata[SEQ_PRED_V];
      st_next.succ   = pwdata[SEQ_SUCC_LSB +: 7];
      st_next.succ_v = pwdata[SEQ_SUCC_V];
    end
    if (wr_acc && paddr == OFS_FAULT_MSK) begin
      st_next.fmask = pwdata[7:0];
    end
    st_next.fstat = st_reg.fstat & ~((wr_acc && paddr == OFS_FAULT_ST) ? pwdata[7:0] : 8'h00);
    st_next.fstat = st_next.fstat | {in_group && evt_in.kind == EVT_FAULT, fault_in};
    if (wr_acc && paddr == OFS_RESTORE) begin
      st_next.rst_def = pwdata[RST_DEF_BIT];
      st_next.rst_fac = pwdata[RST_FAC_BIT] && st_reg.store != STORE_DEFAULT;   // [R22]
      st_next.refused = pwdata[RST_FAC_BIT] && st_reg.store == STORE_DEFAULT;   // [R22]
    end

    // Read data is captured in the setup cycle so it is a flop in the access cycle.
    if (rd_setup) begin
      if (paddr == OFS_CTRL) begin
        st_next.rdata = 32'({st_reg.fan_pulse_input_alw, st_reg.cmd_seq, st_reg.use_prog, st_reg.prog});
      end else if (paddr == OFS_SEQ_ID) begin
        st_next.rdata = 32'({st_reg.succ_v, st_reg.succ, st_reg.pred_v, st_reg.pred});
      end else if (paddr == OFS_FAULT_ST) begin
        st_next.rdata = 32'(st_reg.fstat);
      end else if (paddr == OFS_FAULT_MSK) begin
        st_next.rdata = 32'(st_reg.fmask);
      end else if (paddr == OFS_STATUS) begin
        st_next.rdata = {5'd0, 3'(st_reg.seq), 2'(st_reg.store), 2'(st_reg.sync),
                         2'(st_reg.role), 4'(phase_eff), 7'd0, st_reg.dev_addr};
      end else if (paddr == OFS_RESTORE) begin
        st_next.rdata = 32'({st_reg.refused, 2'b00});
      end else if (paddr == OFS_FAN_PULSE_INPUT_RPM) begin
        st_next.rdata = st_reg.rpm;
      end else if (paddr == OFS_TELEM0) begin
        st_next.rdata = 32'(telem.vin);                       // [R18]
      end else if (paddr == OFS_TELEM0 + 12'h004) begin
        st_next.rdata = 32'(telem.vout);                      // [R18]
      end else if (paddr == OFS_TELEM0 + 12'h008) begin
        st_next.rdata = 32'(telem.iout);                      // [R18]
      end else if (paddr == OFS_TELEM0 + 12'h00c) begin
        st_next.rdata = 32'(telem.temp_int);                  // [R18]
      end else if (paddr == OFS_TELEM0 + 12'h010) begin
        st_next.rdata = 32'(telem.temp_ext);                  // [R18]
      end else if (paddr == OFS_TELEM0 + 12'h014) begin
        st_next.rdata = 32'(telem.freq);                      // [R18]
      end else if (paddr == OFS_TELEM6) begin
        st_next.rdata = 32'(telem.duty);                      // [R18]
      end else begin
        st_next.rdata = 32'h0000_0000;
      end
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg       <= '0;
      st_reg.seq   <= SEQ_OFF;
      st_reg.fmask <= FAULT_MSK_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs; run request follows the sequencer, all others are flops.
  assign prdata              = st_reg.rdata;
  assign evt_out             = st_reg.evt;
  assign run_req             = (st_reg.seq == SEQ_RAMP) || (st_reg.seq == SEQ_ON)
                             || (st_reg.seq == SEQ_WAIT_OFF);
  assign cycle_start         = st_reg.cyc;
  assign sync_mode           = st_reg.sync;
  assign fault_alert_line    = st_reg.alert_q;             // [R17]
  assign restore_default_req = st_reg.rst_def;
  assign restore_factory_req = st_reg.rst_fac;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_phase_auto_addr: assert property (st_reg.init_done && auto_seq |-> phase_eff == {st_reg.dev_addr[2:0], 1'b0}) // [R7]
    else $error("autonomous offset differs from address offset");
  a_cycle_start_slot: assert property (slot_tick && !period_start && 4'(st_reg.slot + 4'd1) == phase_eff |=> cycle_start) // [R1]
    else $error("switching cycle start missed its slot");
  a_prog_offset_used: assert property (!auto_seq && st_reg.use_prog |-> phase_eff == st_reg.prog) // [R3]
    else $error("programmed offset not applied");
  a_wait_pred_hold: assert property (st_reg.seq == SEQ_WAIT_ON && enable_in && !pred_on |=> st_reg.seq == SEQ_WAIT_ON) // [R8]
    else $error("turn-on started without predecessor");
  a_foreign_group_ignored: assert property (evt_in.valid && !in_group && st_reg.seq == SEQ_WAIT_ON && enable_in |=> st_reg.seq == SEQ_WAIT_ON) // [R15]
    else $error("event from another group acted on");
  a_off_waits_succ: assert property (st_reg.seq == SEQ_WAIT_OFF && !succ_off && !in_group |=> run_req) // [R9]
    else $error("turn-off before successor");
  a_on_broadcast: assert property (st_reg.seq == SEQ_RAMP && enable_in && power_good |=> evt_out.valid && evt_out.kind == EVT_ON ##1 !evt_out.valid || evt_out.kind != EVT_ON) // [R5]
    else $error("power-on status not broadcast");
  a_alert_follows: assert property ((|(fault_in & st_reg.fmask[6:0])) |=> ##1 fault_alert_line) // [R17]
    else $error("enabled fault did not raise alert");
  a_factory_refused: assert property (wr_acc && paddr == OFS_RESTORE && pwdata[RST_FAC_BIT] && st_reg.store == STORE_DEFAULT |=> !restore_factory_req && st_reg.refused) // [R22]
    else $error("factory restore not refused");
  a_fan_pulse_input_ignored: assert property (!fan_pulse_input_on && st_reg.win_cnt != 28'(FAN_PULSE_INPUT_WINDOW - 1) |=> $stable(st_reg.fan_pulse_input_cnt)) // [R20]
    else $error("fan pulse counted while idle");
  a_first_starts: assert property (st_reg.seq == SEQ_OFF && en_rise && !st_reg.cmd_seq && st_reg.role == ROLE_FIRST |=> st_reg.seq == SEQ_RAMP ##0 run_req) // [R16]
    else $error("first member did not start");

  c_full_on:    cover property (st_reg.seq == SEQ_WAIT_ON ##1 st_reg.seq == SEQ_RAMP ##[1:50] st_reg.seq == SEQ_ON);
  c_seq_off:    cover property (st_reg.seq == SEQ_WAIT_OFF ##1 st_reg.seq == SEQ_STOP);
  c_refused:    cover property (st_reg.refused);
  c_rpm_update: cover property (st_reg.rpm != 32'd0);

endmodule

// ==== sim/aspsq_peer.sv ====
// Model of the peer converters and of the shared switching timebase.
`timescale 1ns/1ps
module aspsq_peer
  import aspsq_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire aspsq_evt_t req,
  output aspsq_evt_t      evt_in,
  output logic            period_start,
  output logic            slot_tick
);
  logic [4:0] cnt_reg;
  // One timebase feeds every converter, otherwise phase offsets would mean nothing.
  assign slot_tick    = cnt_reg[0];
  assign period_start = (cnt_reg == 5'h01);
  // Peers sit at consecutive addresses; the bench picks which one speaks.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 5'h00;
      evt_in  <= '0;
    end else begin
      cnt_reg <= cnt_reg + 5'h01;
      evt_in  <= req;
    end
  end
endmodule

// ==== sim/aspsq_top_tb.sv ====
// Self-checking bench for the phase-spread and sequencing block.
`timescale 1ns/1ps
module aspsq_top_tb;
  import aspsq_pkg::*;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, perr, enable_in, power_good;
  logic         period_start, slot_tick, run_req, cycle_start, fault_alert_line, fan_pulse_input;
  logic         restore_default_req, restore_factory_req, user_store_ok;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, r;
  logic [1:0]   sync_mode;
  logic [6:0]   fault_in;
  aspsq_evt_t   evt_in, evt_out, req;
  aspsq_telem_t telem;
  int           fails, compares, nfac, ndef;
  // Address 0x21, middle member with the sync pin on auto-detect, default store valid.
  aspsq_top #(.FAN_PULSE_INPUT_WINDOW(100)) i_aspsq_top (.address_strap_low(2'h1), .address_strap_high(2'h0),
    .cfg_index(5'h0d), .default_store_ok(1'b1), .*);
  aspsq_peer i_aspsq_peer (.*);
  // The fan toggles every cycle after reset, so a full window holds half as many edges.
  always @(posedge pclk) fan_pulse_input <= presetn & ~fan_pulse_input;
  // Restore requests are counted mid-cycle so that the edge ordering never matters.
  always @(negedge pclk) begin
    nfac += (restore_factory_req === 1'b1);
    ndef += (restore_default_req === 1'b1);
  end
  task automatic end_sim();
    if (fails == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer; the request holds until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk(n < 20, 1'b1);
    r = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic lvl(ref logic s, input logic e);
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    chk(s, e);
    @(posedge pclk);
  endtask
  task automatic send(input aspsq_kind_t k, input logic [6:0] a);
    req <= '{1'b1, k, a};
    @(posedge pclk);
    req <= '0;
  endtask
  // A lost broadcast would hang the chain, so the wait is bounded.
  task automatic wait_evt(input aspsq_kind_t k);
    int n;
    for (n = 0; n < 40 && !(evt_out.valid === 1'b1 && evt_out.kind === k); n++) @(negedge pclk);
    chk(n < 40, 1'b1);
    chk(evt_out.addr, 7'h21);
    @(posedge pclk);
  endtask
  task automatic t_status();
    int n;
    apb(1'b1, OFS_CTRL, 32'h15);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(r[6:0], 7'h21);
    chk(r[17:14], 4'h2);
    chk(r[21:18], 4'h7);
    chk(r[23:22], 2'h1);
    chk(sync_mode, 2'h1);
    apb(1'b0, OFS_TELEM0, 32'h0);
    chk(r, 32'h1234);
    apb(1'b0, 12'h01c, 32'h0);
    chk(perr, 1'b1);
    // Offset two slots: the cycle starts four edges after the period marker is taken.
    @(negedge pclk);
    for (n = 0; n < 40 && period_start !== 1'b1; n++) @(negedge pclk);
    chk(n < 40, 1'b1);
    repeat (4) @(posedge pclk);
    @(negedge pclk);
    chk(cycle_start, 1'b0);
    @(negedge pclk);
    chk(cycle_start, 1'b1);
    @(posedge pclk);
  endtask
  task automatic t_seq();
    enable_in <= 1'b1;
    send(EVT_ON, 7'h29);
    lvl(run_req, 1'b0);
    send(EVT_ON, 7'h20);
    lvl(run_req, 1'b1);
    power_good <= 1'b1;
    wait_evt(EVT_ON);
    enable_in <= 1'b0;
    lvl(run_req, 1'b1);
    send(EVT_OFF, 7'h22);
    lvl(run_req, 1'b0);
    power_good <= 1'b0;
    wait_evt(EVT_OFF);
  endtask
  task automatic t_misc();
    apb(1'b1, OFS_RESTORE, 32'h2);
    apb(1'b0, OFS_RESTORE, 32'h0);
    chk(r[2], 1'b1);
    apb(1'b1, OFS_RESTORE, 32'h1);
    chk({nfac[3:0], ndef[3:0]}, 8'h01);
    apb(1'b1, OFS_FAULT_MSK, 32'h0);
    fault_in <= 7'h01;
    lvl(fault_alert_line, 1'b0);
    apb(1'b1, OFS_FAULT_MSK, 32'h1);
    lvl(fault_alert_line, 1'b1);
    // Disabled and not monitoring: windows that close now hold no pulses.
    repeat (250) @(posedge pclk);
    apb(1'b0, OFS_FAN_PULSE_INPUT_RPM, 32'h0);
    chk(r, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h75);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(r[17:14], 4'h5);
    repeat (250) @(posedge pclk);
    apb(1'b0, OFS_FAN_PULSE_INPUT_RPM, 32'h0);
    chk(r, 32'(50 * RPM_PER_PPS));
  endtask
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // The whole run is far shorter than this limit; reaching it means a hang.
  initial begin
    #100000;
    fails++;
    end_sim();
  end
  initial begin
    {presetn, psel, penable, pwrite, enable_in, power_good} = '0;
    user_store_ok = 1'b1;
    {fault_in, paddr, pwdata, req} = '0;
    telem = {16'h1234, 96'h0};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    t_status();
    t_seq();
    t_misc();
    end_sim();
  end
endmodule
